// File: hw/bpp_cfg.svh
/*
 * Constants for the battery pack protection controller: timing counts and cell counts.
 * Assumes a 250 MHz clock; included by bare name.
 */
`ifndef BPP_CFG_SVH
`define BPP_CFG_SVH
`define BPP_CLK_MHZ          250
`define BPP_SAMPLE_PERIOD_MS 400
`define BPP_SAMPLE_CYCLES    (`BPP_SAMPLE_PERIOD_MS * 1000 * `BPP_CLK_MHZ)
`define BPP_OCU_DELAY_MS     400
`define BPP_OCU_CYCLES       (`BPP_OCU_DELAY_MS * 1000 * `BPP_CLK_MHZ)
`define BPP_OCO_DELAY_MS     400
`define BPP_OCO_CYCLES       (`BPP_OCO_DELAY_MS * 1000 * `BPP_CLK_MHZ)
`define BPP_REMOVAL_DELAY_MS 100
`define BPP_REMOVAL_CYCLES   (`BPP_REMOVAL_DELAY_MS * 1000 * `BPP_CLK_MHZ)
`define BPP_OV_DELAY_MS      5000
`define BPP_OV_CYCLES        (`BPP_OV_DELAY_MS * 1000 * `BPP_CLK_MHZ)
`define BPP_TEMP_SAMPLES     2
`define BPP_NUM_CELLS        13
`define BPP_CELLS_REDUCED    10
`define BPP_CNT_W            32
`endif

// File: hw/bpp_pkg.sv
/*
 * Types for the battery pack protection controller.
 * Assumes bpp_cfg.svh supplies the numeric constants.
 */
package bpp_pkg;
    typedef enum logic [2:0] {
        BPP_INIT,
        BPP_NORMAL,
        BPP_OVERVOLT,
        BPP_DISCH_OC,
        BPP_CHG_OC,
        BPP_SHORT
    } bpp_state_e;

    typedef struct packed {
        logic discharge_gate_out;
        logic charge_gate_out;
        logic charge_gate_oe;
        logic load_sense_pulldown;
        logic charger_sense_pullup;
    } bpp_gates_s;
endpackage : bpp_pkg

// File: hw/bpp_fsm.sv
/*
 * Protection state machine for a multi-cell battery pack: comparator results in, switch gate drives out.
 * Assumes all comparator inputs are synchronous to clk; analog parts (pull resistors, delay capacitor) sit outside.
 */
`timescale 1ns/100ps
`include "bpp_cfg.svh"

module bpp_fsm #(
    parameter int                  NUM_CELLS      = `BPP_NUM_CELLS,
    parameter int                  CELLS_REDUCED  = `BPP_CELLS_REDUCED,
    parameter logic [`BPP_CNT_W-1:0] SAMPLE_CYCLES  = `BPP_SAMPLE_CYCLES,
    parameter logic [`BPP_CNT_W-1:0] OV_CYCLES      = `BPP_OV_CYCLES,
    parameter logic [`BPP_CNT_W-1:0] OCU_CYCLES     = `BPP_OCU_CYCLES,
    parameter logic [`BPP_CNT_W-1:0] OCO_CYCLES     = `BPP_OCO_CYCLES,
    parameter logic [`BPP_CNT_W-1:0] REMOVAL_CYCLES = `BPP_REMOVAL_CYCLES,
    parameter int                  TEMP_SAMPLES   = `BPP_TEMP_SAMPLES
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 regulator_dropped,
    input  wire logic                 regulator_released,
    input  wire logic                 cell_count_reduced,
    input  wire logic [NUM_CELLS-1:0] cell_above_undervolt_release,
    input  wire logic [NUM_CELLS-1:0] cell_above_overvolt_detect,
    input  wire logic [NUM_CELLS-1:0] cell_above_overvolt_release,
    input  wire logic                 current_above_discharge_oc,
    input  wire logic                 current_below_charge_oc,
    input  wire logic                 current_above_short,
    input  wire logic                 short_delay_cap_tripped,
    input  wire logic                 thermistor_below_hot_charge,
    input  wire logic                 thermistor_above_cold_charge,
    input  wire logic                 thermistor_below_hot_discharge,
    input  wire logic                 load_sense_below_removal,
    input  wire logic                 charger_sense_above_removal,
    output logic                      discharge_gate_out,
    output logic                      charge_gate_out,
    output logic                      charge_gate_oe,
    output logic                      load_sense_pulldown,
    output logic                      charger_sense_pullup,
    output logic                      short_delay_cap_charge,
    output logic [2:0]                state_out
);
    localparam int TW = $clog2(TEMP_SAMPLES + 1);
    localparam logic [TW-1:0] TEMP_N = TW'(TEMP_SAMPLES);

    typedef struct packed {
        bpp_pkg::bpp_state_e    state;
        bpp_pkg::bpp_gates_s    gates;
        logic                   cap_charge;
        logic [`BPP_CNT_W-1:0]  sample_cnt;
        logic [`BPP_CNT_W-1:0]  ov_cnt;
        logic [`BPP_CNT_W-1:0]  oc_cnt;
        logic [`BPP_CNT_W-1:0]  rel_cnt;
        logic                   ov_seen;
        logic                   ov_clear;
        logic [TW-1:0]          hot_chg_cnt;
        logic [TW-1:0]          cold_chg_cnt;
        logic [TW-1:0]          hot_dis_cnt;
        logic                   hot_chg;
        logic                   cold_chg;
        logic                   hot_dis;
        logic                   dis_oc_seen;
        logic                   chg_oc_seen;
    } bpp_fsm_s;

    bpp_fsm_s s_q;
    bpp_fsm_s s_d;

    logic [NUM_CELLS-1:0] cell_sel;
    logic                 sample_tick;
    logic                 all_uv_ok;
    logic                 any_ov;
    logic                 all_ov_released;

    // Unused cells in reduced mode are the lowest three inputs, which cell_sel masks out here.
    genvar g;
    generate
        for (g = 0; g < NUM_CELLS; g++) begin : g_sel
            assign cell_sel[g] = !(cell_count_reduced && (g < NUM_CELLS - CELLS_REDUCED));
        end
    endgenerate

    assign sample_tick     = (s_q.sample_cnt == SAMPLE_CYCLES - 1);
    assign all_uv_ok       = &(cell_above_undervolt_release | ~cell_sel);
    assign any_ov          = |(cell_above_overvolt_detect & cell_sel);
    assign all_ov_released = ~|(cell_above_overvolt_release & cell_sel);

    always_comb begin
        s_d = s_q;
        s_d.sample_cnt = sample_tick ? '0 : s_q.sample_cnt + 1'b1;

        // Cell results are latched only on the sample tick; the delay counter restarts when a sample clears.
        if (sample_tick) begin
            s_d.ov_seen  = any_ov;
            s_d.ov_clear = all_ov_released;
        end
        if (!s_d.ov_seen || s_q.state == bpp_pkg::BPP_OVERVOLT) begin
            s_d.ov_cnt = '0;
        end else if (s_q.ov_cnt != OV_CYCLES) begin
            s_d.ov_cnt = s_q.ov_cnt + 1'b1;
        end

        // Temperature debounce counts consecutive samples in each direction.
        if (sample_tick) begin
            s_d.hot_chg_cnt  = (thermistor_below_hot_charge != s_q.hot_chg) ? s_q.hot_chg_cnt + 1'b1 : '0;
            s_d.cold_chg_cnt = (thermistor_above_cold_charge != s_q.cold_chg) ? s_q.cold_chg_cnt + 1'b1 : '0;
            s_d.hot_dis_cnt  = (thermistor_below_hot_discharge != s_q.hot_dis) ? s_q.hot_dis_cnt + 1'b1 : '0;
            if (s_d.hot_chg_cnt == TEMP_N) begin
                s_d.hot_chg     = thermistor_below_hot_charge;
                s_d.hot_chg_cnt = '0;
            end
            if (s_d.cold_chg_cnt == TEMP_N) begin
                s_d.cold_chg     = thermistor_above_cold_charge;
                s_d.cold_chg_cnt = '0;
            end
            if (s_d.hot_dis_cnt == TEMP_N) begin
                s_d.hot_dis     = thermistor_below_hot_discharge;
                s_d.hot_dis_cnt = '0;
            end
        end

        // Overcurrent timing runs every cycle, independent of sampling.
        s_d.cap_charge = current_above_short;
        if (current_above_discharge_oc && !s_q.chg_oc_seen) begin
            s_d.dis_oc_seen = 1'b1;
            s_d.oc_cnt = (s_q.oc_cnt == OCU_CYCLES) ? s_q.oc_cnt : s_q.oc_cnt + 1'b1;
        end else if (current_below_charge_oc && !s_q.dis_oc_seen) begin
            s_d.chg_oc_seen = 1'b1;
            s_d.oc_cnt = (s_q.oc_cnt == OCO_CYCLES) ? s_q.oc_cnt : s_q.oc_cnt + 1'b1;
        end else begin
            s_d.oc_cnt      = '0;
            s_d.dis_oc_seen = 1'b0;
            s_d.chg_oc_seen = 1'b0;
        end

        unique case (s_q.state)
            bpp_pkg::BPP_INIT, bpp_pkg::BPP_NORMAL, bpp_pkg::BPP_OVERVOLT: begin
                s_d.rel_cnt = '0;
                if (s_q.state == bpp_pkg::BPP_INIT && regulator_dropped) begin
                    s_d.gates.discharge_gate_out = 1'b0;
                    s_d.gates.charge_gate_out    = 1'b1;
                    s_d.gates.charge_gate_oe     = 1'b1;
                end
                if (short_delay_cap_tripped) begin
                    s_d.state = bpp_pkg::BPP_SHORT;
                end else if (s_q.dis_oc_seen && s_q.oc_cnt == OCU_CYCLES) begin
                    s_d.state = bpp_pkg::BPP_DISCH_OC;
                end else if (s_q.chg_oc_seen && s_q.oc_cnt == OCO_CYCLES) begin
                    s_d.state = bpp_pkg::BPP_CHG_OC;
                end else if (s_q.state != bpp_pkg::BPP_OVERVOLT && s_q.ov_cnt == OV_CYCLES) begin
                    s_d.state = bpp_pkg::BPP_OVERVOLT;
                end else if (s_q.state == bpp_pkg::BPP_OVERVOLT && sample_tick && all_ov_released) begin
                    s_d.state = bpp_pkg::BPP_NORMAL;
                end else if (s_q.state == bpp_pkg::BPP_INIT && regulator_released && sample_tick && all_uv_ok) begin
                    s_d.state = bpp_pkg::BPP_NORMAL;
                end
            end
            bpp_pkg::BPP_DISCH_OC, bpp_pkg::BPP_SHORT: begin
                if (!load_sense_below_removal) begin
                    s_d.rel_cnt = '0;
                end else if (s_q.rel_cnt == REMOVAL_CYCLES) begin
                    s_d.state = bpp_pkg::BPP_NORMAL;
                end else begin
                    s_d.rel_cnt = s_q.rel_cnt + 1'b1;
                end
            end
            bpp_pkg::BPP_CHG_OC: begin
                if (!charger_sense_above_removal) begin
                    s_d.rel_cnt = '0;
                end else if (s_q.rel_cnt == REMOVAL_CYCLES) begin
                    s_d.state = bpp_pkg::BPP_NORMAL;
                end else begin
                    s_d.rel_cnt = s_q.rel_cnt + 1'b1;
                end
            end
        endcase

        // Gate drive is recomputed from the next state; overcurrent and short states take priority.
        s_d.gates.load_sense_pulldown  = 1'b0;
        s_d.gates.charger_sense_pullup = 1'b0;
        unique case (s_d.state)
            bpp_pkg::BPP_INIT: begin
            end
            bpp_pkg::BPP_NORMAL: begin
                s_d.gates.discharge_gate_out = 1'b1;
                s_d.gates.charge_gate_out    = 1'b1;
                s_d.gates.charge_gate_oe     = 1'b1;
            end
            bpp_pkg::BPP_OVERVOLT, bpp_pkg::BPP_CHG_OC: begin
                s_d.gates.charge_gate_out      = 1'b0;
                s_d.gates.charge_gate_oe       = 1'b0;
                s_d.gates.charger_sense_pullup = (s_d.state == bpp_pkg::BPP_CHG_OC);
            end
            bpp_pkg::BPP_DISCH_OC, bpp_pkg::BPP_SHORT: begin
                s_d.gates.discharge_gate_out  = 1'b0;
                s_d.gates.charge_gate_out     = 1'b0;
                s_d.gates.charge_gate_oe      = 1'b0;
                s_d.gates.load_sense_pulldown = 1'b1;
            end
        endcase
        if (s_d.state != bpp_pkg::BPP_INIT && (s_d.hot_chg || s_d.cold_chg)) begin
            s_d.gates.charge_gate_out = 1'b0;
            s_d.gates.charge_gate_oe  = 1'b0;
        end
        if (s_d.state != bpp_pkg::BPP_INIT && s_d.hot_dis) begin
            s_d.gates.discharge_gate_out = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0; // Initial state, both gates off and released.
        end else begin
            s_q <= s_d;
        end
    end

    assign discharge_gate_out     = s_q.gates.discharge_gate_out;
    assign charge_gate_out        = s_q.gates.charge_gate_out;
    assign charge_gate_oe         = s_q.gates.charge_gate_oe;
    assign load_sense_pulldown    = s_q.gates.load_sense_pulldown;
    assign charger_sense_pullup   = s_q.gates.charger_sense_pullup;
    assign short_delay_cap_charge = s_q.cap_charge;
    assign state_out              = s_q.state;
endmodule : bpp_fsm

// File: sim/bpp_fsm_props.sv
/* Checker for the pack protection state machine, bound to every bpp_fsm.
   Sees only the ports of bpp_fsm; delay counts come in as parameters. */
`timescale 1ns/100ps
module bpp_fsm_props #(
    parameter logic [31:0] OCU_CYCLES     = 32'h1E,
    parameter logic [31:0] REMOVAL_CYCLES = 32'h0A
) (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       current_above_discharge_oc,
    input wire logic       current_above_short,
    input wire logic       load_sense_below_removal,
    input wire logic       discharge_gate_out,
    input wire logic       charge_gate_out,
    input wire logic       charge_gate_oe,
    input wire logic       load_sense_pulldown,
    input wire logic       charger_sense_pullup,
    input wire logic       short_delay_cap_charge,
    input wire logic [2:0] state_out
);
    logic [31:0] oc_run_q;
    logic [31:0] rm_run_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Runs of consecutive high samples, to judge how long a cause was held.
    always_ff @(posedge clk) begin
        oc_run_q <= (!rstn || !current_above_discharge_oc) ? 32'h0 : oc_run_q + 32'h1;
        rm_run_q <= (!rstn || !load_sense_below_removal) ? 32'h0 : rm_run_q + 32'h1;
    end
    reset_clear_a: assert property ($rose(rstn) |-> state_out == 3'h0 && !discharge_gate_out && !charge_gate_oe)
        else $error("outputs not cleared by reset");
    cap_follow_a: assert property ($past(rstn) |-> short_delay_cap_charge == $past(current_above_short))
        else $error("capacitor charge does not follow short level");
    disch_gates_a: assert property (state_out == 3'h3 |-> !discharge_gate_out && !charge_gate_oe && load_sense_pulldown)
        else $error("wrong gates in discharge overcurrent");
    short_gates_a: assert property (state_out == 3'h5 |-> !discharge_gate_out && !charge_gate_oe && load_sense_pulldown)
        else $error("wrong gates in short circuit");
    chg_gates_a: assert property (state_out == 3'h4 |-> !charge_gate_oe && !charge_gate_out && charger_sense_pullup)
        else $error("wrong gates in charge overcurrent");
    ov_gate_a: assert property (state_out == 3'h2 |-> !charge_gate_oe && !charge_gate_out)
        else $error("charge gate driven in overvoltage");
    oc_delay_a: assert property ($changed(state_out) && state_out == 3'h3 |-> oc_run_q >= OCU_CYCLES)
        else $error("discharge overcurrent entered too early");
    removal_delay_a: assert property ($changed(state_out) && state_out == 3'h1
        && ($past(state_out) == 3'h3 || $past(state_out) == 3'h5) |-> rm_run_q >= REMOVAL_CYCLES)
        else $error("load removal recovery too early");
    cover property (state_out == 3'h3);
    cover property (state_out == 3'h5);
    cover property (state_out == 3'h2);
endmodule : bpp_fsm_props

bind bpp_fsm bpp_fsm_props #(.OCU_CYCLES(OCU_CYCLES), .REMOVAL_CYCLES(REMOVAL_CYCLES)) u_props (.*);

// File: sim/bpp_pack_model.sv
/* Behavioural far side of the pack: load, charger and short delay capacitor.
   Assumes the bench says whether a load and a charger are attached. */
`timescale 1ns/100ps
module bpp_pack_model #(
    parameter int CAP_TRIP = 5
) (
    input  wire logic clk,
    input  wire logic load_sense_pulldown,
    input  wire logic charger_sense_pullup,
    input  wire logic short_delay_cap_charge,
    input  wire logic load_present,
    input  wire logic charger_present,
    output logic      load_sense_below_removal,
    output logic      charger_sense_above_removal,
    output logic      short_delay_cap_tripped
);
    int   cap_q    = 0;
    logic wobble_q = 1'b0;
    // A sense pin with no pull applied floats, so its comparator shows a changing pattern.
    always @(posedge clk) begin
        wobble_q <= ~wobble_q;
        cap_q    <= short_delay_cap_charge ? cap_q + 1 : 0;
    end
    assign short_delay_cap_tripped     = cap_q >= CAP_TRIP;
    assign load_sense_below_removal    = load_sense_pulldown ? !load_present : wobble_q;
    assign charger_sense_above_removal = charger_sense_pullup ? !charger_present : wobble_q;
endmodule : bpp_pack_model

// File: sim/bpp_fsm_tb.sv
/* Self-checking bench for bpp_fsm with shortened delay counts.
   Assumes bpp_pack_model stands in for the load, charger and capacitor. */
`timescale 1ns/100ps
module bpp_fsm_tb;
    typedef struct packed { logic [2:0] st; logic dg; logic oe; } bpp_note_s;
    logic        clk = 1'b0, rstn = 1'b0, regulator_dropped = 1'b1, regulator_released = 1'b0;
    logic        cell_count_reduced = 1'b0, current_above_discharge_oc = 1'b0, current_below_charge_oc = 1'b0;
    logic        current_above_short = 1'b0, thermistor_below_hot_charge = 1'b0, ov_on = 1'b0;
    logic        thermistor_above_cold_charge = 1'b0, thermistor_below_hot_discharge = 1'b0;
    logic        load_present = 1'b1, charger_present = 1'b1;
    logic [3:0]  ov_cell = 4'h3;
    logic [12:0] cell_above_undervolt_release = 13'h1FFF;
    wire  [12:0] cell_above_overvolt_detect  = ov_on ? 13'h1 << ov_cell : 13'h0;
    wire  [12:0] cell_above_overvolt_release = cell_above_overvolt_detect;
    logic        load_sense_below_removal, charger_sense_above_removal, short_delay_cap_tripped;
    logic        discharge_gate_out, charge_gate_out, charge_gate_oe, load_sense_pulldown;
    logic        charger_sense_pullup, short_delay_cap_charge;
    logic [2:0]  state_out, prev_state = 3'h0;
    bpp_note_s   notes[$];
    bpp_note_s   note;
    int          n_errors = 0, samples_checked = 0, cycles = 0, k;

    bpp_fsm #(.SAMPLE_CYCLES(32'h14), .OV_CYCLES(32'h32), .OCU_CYCLES(32'h1E), .OCO_CYCLES(32'h1E),
              .REMOVAL_CYCLES(32'h0A)) DUT (.*);
    bpp_pack_model u_pack (.*);

    initial forever #2 clk = ~clk;

    task automatic check_val(input string what, input logic [2:0] exp, input logic [2:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check_val

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    task automatic wait_state(input logic [2:0] s);
        for (int i = 0; i < 300 && state_out !== s; i++) @(posedge clk);
    endtask : wait_state

    task automatic run_fault(input logic [3:0] f, input logic [2:0] st, input logic dg);
        notes.push_back('{st, dg, 1'b0});
        notes.push_back('{3'h1, 1'b1, 1'b1});
        @(posedge clk);
        {ov_on, current_above_short, current_below_charge_oc, current_above_discharge_oc} <= f;
        {load_present, charger_present} <= 2'h3;
        wait_state(st);
        @(posedge clk);
        {ov_on, current_above_short, current_below_charge_oc, current_above_discharge_oc} <= 4'h0;
        {load_present, charger_present} <= 2'h0;
        wait_state(3'h1);
    endtask : run_fault

    // Each change of state takes the oldest note and compares state and gates.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
        #1;
        if (rstn && state_out !== prev_state) begin
            note = notes.size() ? notes.pop_front() : '{3'h7, 1'b0, 1'b0};
            check_val("state", note.st, state_out);
            check_val("gates", {1'b0, note.dg, note.oe}, {1'b0, discharge_gate_out, charge_gate_oe});
        end
        prev_state = state_out;
    end

    initial begin
        void'($urandom(32'h208B));
        ov_cell = 4'h3 + 4'($urandom % 10);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check_val("init gates", 3'h3, {discharge_gate_out, charge_gate_out, charge_gate_oe});
        notes.push_back('{3'h1, 1'b1, 1'b1});
        @(posedge clk);
        {regulator_dropped, regulator_released} <= 2'h1;
        wait_state(3'h1);
        // Overcurrent runs shorter than the delay must not trip.
        for (k = 0; k < 4; k++) begin
            repeat (20) @(posedge clk);
            current_above_discharge_oc <= ~k[0];
        end
        repeat (40) @(posedge clk);
        #1;
        check_val("after dropouts", 3'h1, state_out);
        run_fault(4'h1, 3'h3, 1'b0);
        run_fault(4'h4, 3'h5, 1'b0);
        run_fault(4'h2, 3'h4, 1'b1);
        run_fault(4'h8, 3'h2, 1'b1);
        @(posedge clk);
        {cell_count_reduced, ov_cell, ov_on} <= 6'h23;
        repeat (150) @(posedge clk);
        #1;
        check_val("ignored cell", 3'h1, state_out);
        @(posedge clk);
        {cell_count_reduced, ov_on} <= 2'h0;
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            {thermistor_below_hot_discharge, thermistor_above_cold_charge, thermistor_below_hot_charge} <= 3'h1 << k;
            repeat (64) @(posedge clk);
            #1;
            check_val("temp gates", {1'b0, k != 2, k == 2}, {1'b0, discharge_gate_out, charge_gate_oe});
            @(posedge clk);
            {thermistor_below_hot_discharge, thermistor_above_cold_charge, thermistor_below_hot_charge} <= 3'h0;
            repeat (64) @(posedge clk);
            #1;
            check_val("temp cleared", 3'h3, {1'b0, discharge_gate_out, charge_gate_oe});
        end
        check_val("pending notes", 3'h0, 3'(notes.size()));
        final_report();
    end
endmodule : bpp_fsm_tb
